// ### hw/node_leader_framer.sv
// Purpose: builds node-to-host leaders, arbitrates messages, serialises them with end padding
// Assumes: all inputs synchronous to clk; message sources hold leader fields while valid
// Notes: one refusal slot and one outstanding ready per block
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// RULE1 - message type code in leader bits 25-32
// RULE2 - try-again sub-type: buffer 0, block 1
// RULE3 - markable refusal gives 12, later 14
// RULE4 - will-notify sub-types two to five
// RULE5 - second refusal while ready pending gives 13
// RULE6 - ready names the refused message id
// RULE7 - non-regular messages go before regular ones
// RULE8 - handling type bits 33-40, listed types only
// RULE9 - host and node fields per type
// RULE10 - message-id bits 65-76 for listed types
// RULE11 - sub-type bits 77-80 for listed types
// RULE12 - length bits 81-96 only in regular
// RULE13 - supplied length passed through unchecked
// RULE14 - end of message: one, then zeros
// RULE15 - receiving host pads with zeros only
// RULE16 - receiving host accepts up to 8160 bits
// RULE17 - receiving host discards longer than 8160
// RULE18 - leader padding whole 16-bit words after leader
// RULE19 - loopback returns local messages, replacing addresses
// RULE20 - host treats types 15-255 as unassigned
module node_leader_framer
    import node_leader_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic refuseValid,
    input wire logic refuseMarkable,
    input wire logic [3:0] refuseCode,
    input wire logic [7:0] refuseHandling,
    input wire logic [7:0] refuseHost,
    input wire logic [15:0] refuseNode,
    input wire logic [11:0] refuseMsgId,
    output logic refuseReady,
    input wire logic resourceFree,
    input wire logic netValid,
    input wire logic netBit,
    input wire logic netLast,
    input wire logic [7:0] netHandling,
    input wire logic [7:0] netHost,
    input wire logic [15:0] netNode,
    input wire logic [11:0] netMsgId,
    input wire logic [3:0] netSub,
    input wire logic [15:0] netLength,
    output logic netReady,
    input wire logic loopValid,
    input wire logic loopBit,
    input wire logic loopLast,
    input wire logic [7:0] loopHandling,
    input wire logic [11:0] loopMsgId,
    input wire logic [3:0] loopSub,
    input wire logic [15:0] loopLength,
    output logic loopReady,
    output logic hostBit,
    output logic hostValid,
    output logic hostLast,
    input wire logic hostReady
);
    typedef enum logic [2:0] {IDLE, LEADER, LPAD, DATA, EOM, FILL} tx_state_t;
    tx_state_t state_r;
    logic [31:0] ctrl_r, localNode_r, msg0_r, msg1_r, msg2_r;
    logic ctrlPending_r, refFull_r, readyPending_r, rdyQueued_r;
    logic [7:0] refType_r, refHandling_r, refHost_r, rdyHandling_r, rdyHost_r;
    logic [3:0] refSub_r;
    logic [15:0] refNode_r, rdyNode_r;
    logic [11:0] refMsgId_r, rdyMsgId_r;
    logic [95:0] sh_r, nextLeader;
    logic [6:0] bitCnt_r;
    logic [7:0] padLeft_r;
    logic [3:0] pos_r;
    logic regular_r, fromLoop_r, outBit_r, outValid_r, outLast_r;
    logic adv, loadMsg, pickRef, pickRdy, pickCtrl, pickNet, pickLoop, loopEn, refAccept;
    logic srcValid, srcBit, srcLast, wbReq;
    logic [7:0] pickType;

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : mergeBytes

    assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign loopEn = ctrl_r[CTRL_LOOP_BIT];

    // wishbone slave: one-cycle registered ack, unmapped reads zero
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wbReq;
            if (wbReq && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    ADDR_CTRL: wb_dat_o <= ctrl_r;
                    ADDR_LOCAL_NODE: wb_dat_o <= localNode_r;
                    ADDR_MSG0: wb_dat_o <= msg0_r;
                    ADDR_MSG1: wb_dat_o <= msg1_r;
                    ADDR_MSG2: wb_dat_o <= msg2_r;
                    ADDR_CMD: wb_dat_o <= {28'h0000000, state_r != IDLE, rdyQueued_r, readyPending_r,
                        ctrlPending_r};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_r <= CTRL_RESET;
            localNode_r <= MSG_RESET;
            msg0_r <= MSG_RESET;
            msg1_r <= MSG_RESET;
            msg2_r <= MSG_RESET;
        end
        else if (wbReq && wb_we_i)
        begin
            if (wb_adr_i == ADDR_CTRL) ctrl_r <= mergeBytes(ctrl_r, wb_dat_i, wb_sel_i);
            if (wb_adr_i == ADDR_LOCAL_NODE) localNode_r <= mergeBytes(localNode_r, wb_dat_i, wb_sel_i);
            if (wb_adr_i == ADDR_MSG0) msg0_r <= mergeBytes(msg0_r, wb_dat_i, wb_sel_i);
            if (wb_adr_i == ADDR_MSG1) msg1_r <= mergeBytes(msg1_r, wb_dat_i, wb_sel_i);
            if (wb_adr_i == ADDR_MSG2) msg2_r <= mergeBytes(msg2_r, wb_dat_i, wb_sel_i);
        end
    end

    // software control message: a new send request wins over the clear
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrlPending_r <= 1'b0;
        else if (wbReq && wb_we_i && wb_adr_i == ADDR_CMD && wb_sel_i[0] && wb_dat_i[CMD_SEND_BIT])
            ctrlPending_r <= 1'b1;
        else if (loadMsg && pickCtrl)
            ctrlPending_r <= 1'b0;
    end

    assign refuseReady = !refFull_r;
    assign refAccept = refuseValid && refuseReady;

    // refusal slot: try-again, will-notify or still-trying
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            refFull_r <= 1'b0;
            refType_r <= TYPE_TRY_AGAIN;
            refSub_r <= SUB_NO_BUFFER;
            refHandling_r <= 8'h00;
            refHost_r <= 8'h00;
            refNode_r <= 16'h0000;
            refMsgId_r <= 12'h000;
        end
        else if (refAccept)
        begin
            refFull_r <= 1'b1;
            refHandling_r <= refuseHandling;
            refHost_r <= refuseHost;
            refNode_r <= refuseNode;
            refMsgId_r <= refuseMsgId;
            refSub_r <= refuseCode; // [RULE2] [RULE4]
            if (!refuseMarkable)
                refType_r <= TYPE_TRY_AGAIN; // [RULE2]
            else if (readyPending_r)
                refType_r <= TYPE_STILL_TRYING; // [RULE5]
            else
                refType_r <= TYPE_WILL_NOTIFY; // [RULE3]
        end
        else if (loadMsg && pickRef)
            refFull_r <= 1'b0;
    end

    // one outstanding ready; holds the refused message for naming
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            readyPending_r <= 1'b0;
            rdyQueued_r <= 1'b0;
            rdyHandling_r <= 8'h00;
            rdyHost_r <= 8'h00;
            rdyNode_r <= 16'h0000;
            rdyMsgId_r <= 12'h000;
        end
        else
        begin
            if (refAccept && refuseMarkable && !readyPending_r)
            begin
                readyPending_r <= 1'b1; // [RULE3]
                rdyHandling_r <= refuseHandling;
                rdyHost_r <= refuseHost;
                rdyNode_r <= refuseNode;
                rdyMsgId_r <= refuseMsgId; // [RULE6]
            end
            else if (loadMsg && pickRdy)
            begin
                readyPending_r <= 1'b0;
            end
            if (loadMsg && pickRdy)
                rdyQueued_r <= 1'b0;
            else if (resourceFree && readyPending_r)
                rdyQueued_r <= 1'b1; // [RULE3] [RULE6]
        end
    end

    // arbitration: every non-regular message ahead of regular ones [RULE7]
    assign pickRef = refFull_r;
    assign pickRdy = !refFull_r && rdyQueued_r;
    assign pickCtrl = !refFull_r && !rdyQueued_r && ctrlPending_r;
    assign pickLoop = !refFull_r && !rdyQueued_r && !ctrlPending_r && loopEn && loopValid;
    assign pickNet = !refFull_r && !rdyQueued_r && !ctrlPending_r && !loopEn && netValid;
    assign adv = !outValid_r || hostReady;
    assign loadMsg = (state_r == IDLE) && adv && (pickRef || pickRdy || pickCtrl || pickLoop || pickNet);

    // leader fields masked per type; supplied length passed unchecked [RULE8] [RULE9] [RULE10] [RULE11] [RULE12] [RULE13]
    always_comb
    begin
        pickType = TYPE_REGULAR;
        nextLeader = '0;
        if (pickRef)
        begin
            pickType = refType_r;
            nextLeader = buildLeader(refType_r, refHandling_r, refHost_r, refNode_r, refMsgId_r, refSub_r, 16'h0000);
        end
        else if (pickRdy)
        begin
            pickType = TYPE_READY;
            nextLeader = buildLeader(TYPE_READY, rdyHandling_r, rdyHost_r, rdyNode_r, rdyMsgId_r, 4'h0, 16'h0000);
        end
        else if (pickCtrl)
        begin
            pickType = msg0_r[7:0];
            nextLeader = buildLeader(msg0_r[7:0], msg0_r[23:16], msg1_r[23:16], msg1_r[15:0], msg2_r[11:0],
                msg0_r[11:8], 16'h0000);
        end
        else if (pickLoop)
            // loopback: only host and node replaced [RULE19]
            nextLeader = buildLeader(TYPE_REGULAR, loopHandling, ctrl_r[CTRL_HOST_LSB +: 8], localNode_r[15:0],
                loopMsgId, loopSub, loopLength);
        else if (pickNet)
            nextLeader = buildLeader(TYPE_REGULAR, netHandling, netHost, netNode, netMsgId, netSub, netLength);
    end

    assign srcValid = fromLoop_r ? loopValid : netValid;
    assign srcBit = fromLoop_r ? loopBit : netBit;
    assign srcLast = fromLoop_r ? loopLast : netLast;
    assign netReady = (state_r == DATA) && adv && !fromLoop_r;
    assign loopReady = (state_r == DATA) && adv && fromLoop_r;
    assign hostBit = outBit_r;
    assign hostValid = outValid_r;
    assign hostLast = outLast_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r <= IDLE;
            sh_r <= '0;
            bitCnt_r <= 7'h00;
            padLeft_r <= 8'h00;
            pos_r <= 4'h0;
            regular_r <= 1'b0;
            fromLoop_r <= 1'b0;
            outBit_r <= 1'b0;
            outValid_r <= 1'b0;
            outLast_r <= 1'b0;
        end
        else if (adv)
        begin
            outLast_r <= 1'b0;
            unique case (state_r)
                IDLE:
                begin
                    outValid_r <= 1'b0;
                    if (loadMsg)
                    begin
                        sh_r <= nextLeader; // [RULE1]
                        regular_r <= pickType == TYPE_REGULAR;
                        fromLoop_r <= pickLoop;
                        padLeft_r <= {ctrl_r[CTRL_PAD_LSB +: 4], 4'h0};
                        bitCnt_r <= 7'h00;
                        state_r <= LEADER;
                    end
                end
                LEADER:
                begin
                    outBit_r <= sh_r[95];
                    outValid_r <= 1'b1;
                    sh_r <= {sh_r[94:0], 1'b0};
                    bitCnt_r <= bitCnt_r + 7'h01;
                    pos_r <= 4'h0;
                    if (bitCnt_r == 7'(LEADER_BITS - 1))
                    begin
                        if (!regular_r)
                        begin
                            outLast_r <= 1'b1;
                            state_r <= IDLE;
                        end
                        else
                            state_r <= (padLeft_r != 8'h00) ? LPAD : DATA; // [RULE18]
                    end
                end
                LPAD:
                begin
                    outBit_r <= 1'b0; // [RULE18]
                    outValid_r <= 1'b1;
                    padLeft_r <= padLeft_r - 8'h01;
                    if (padLeft_r == 8'h01) state_r <= DATA;
                end
                DATA:
                begin
                    outValid_r <= srcValid;
                    outBit_r <= srcBit;
                    if (srcValid)
                    begin
                        pos_r <= pos_r + 4'h1;
                        if (srcLast) state_r <= EOM;
                    end
                end
                EOM:
                begin
                    outBit_r <= 1'b1; // [RULE14]
                    outValid_r <= 1'b1;
                    pos_r <= pos_r + 4'h1;
                    if (pos_r == 4'(NODE_WORD_BITS - 1))
                    begin
                        outLast_r <= 1'b1;
                        state_r <= IDLE;
                    end
                    else
                        state_r <= FILL;
                end
                FILL:
                begin
                    outBit_r <= 1'b0; // [RULE14]
                    outValid_r <= 1'b1;
                    pos_r <= pos_r + 4'h1;
                    if (pos_r == 4'(NODE_WORD_BITS - 1))
                    begin
                        outLast_r <= 1'b1;
                        state_r <= IDLE;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    type_field_a: assert property (loadMsg |=> sh_r[TYPE_LSB +: 8] == $past(pickType)) // [RULE1]
        else $error("leader type field wrong");
    try_sub_a: assert property (loadMsg && pickRef && refType_r == TYPE_TRY_AGAIN |=> sh_r[SUB_LSB +: 4] <= 4'h1) // [RULE2]
        else $error("try-again sub-type out of range");
    mark_ready_a: assert property (refAccept && refuseMarkable && !readyPending_r |=> readyPending_r && refType_r == TYPE_WILL_NOTIFY) // [RULE3]
        else $error("markable refusal did not arm ready");
    still_try_a: assert property (refAccept && refuseMarkable && readyPending_r // [RULE5]
        |=> refType_r == TYPE_STILL_TRYING && $stable(rdyMsgId_r)) else $error("still-trying not given");
    ready_id_a: assert property (loadMsg && pickRdy |=> sh_r[MSGID_LSB +: 12] == $past(rdyMsgId_r) && sh_r[TYPE_LSB +: 8] == TYPE_READY) // [RULE6]
        else $error("ready does not name message");
    prio_order_a: assert property (loadMsg && nextLeader[TYPE_LSB +: 8] == TYPE_REGULAR // [RULE7]
        |-> !refFull_r && !rdyQueued_r) else $error("regular sent before other message");
    unused_zero_a: assert property (loadMsg && !usesHandling(pickType) |=> sh_r[HANDLING_LSB +: 8] == 8'h00 && sh_r[LEN_LSB +: 16] == 16'h0000) // [RULE8]
        else $error("unused field not zero");
    eom_one_a: assert property (state_r == EOM && adv |=> outBit_r && outValid_r) // [RULE14]
        else $error("end of message one missing");
    pad_zero_a: assert property (state_r == LPAD && adv |=> !outBit_r && outValid_r) // [RULE18]
        else $error("leader pad bit not zero");
    loop_addr_a: assert property (loadMsg && pickLoop |=> sh_r[HOST_LSB +: 8] == $past(ctrl_r[CTRL_HOST_LSB +: 8]) && sh_r[NODE_LSB +: 16] == $past(localNode_r[15:0])) // [RULE19]
        else $error("loopback address not replaced");
    notify_cycle_c: cover property (loadMsg && pickRef && refType_r == TYPE_WILL_NOTIFY ##[1:200] loadMsg && pickRdy);
    still_try_c: cover property (refAccept && refuseMarkable && readyPending_r);
    loop_msg_c: cover property (fromLoop_r && outLast_r && outValid_r && hostReady);
endmodule : node_leader_framer

// ### hw/node_leader_pkg.sv
// Purpose: constants and leader field helpers for the node-to-host leader framer
// Assumes: leader bit n (1..96) sits at vector index 96-n, sent first-bit first
// Notes: register offsets are byte addresses on a 32-bit bus
package node_leader_pkg;
    localparam int LEADER_BITS = 96;
    localparam int NODE_WORD_BITS = 16;
    localparam int PAD_WORD_BITS = 16;
    localparam int MAX_MSG_BITS = 8160;
    // field positions inside the 96-bit leader vector
    localparam int TYPE_LSB = 64;
    localparam int HANDLING_LSB = 56;
    localparam int HOST_LSB = 48;
    localparam int NODE_LSB = 32;
    localparam int MSGID_LSB = 20;
    localparam int SUB_LSB = 16;
    localparam int LEN_LSB = 0;
    // message types
    localparam logic [7:0] TYPE_REGULAR = 8'h00;
    localparam logic [7:0] TYPE_TRY_AGAIN = 8'h0B;
    localparam logic [7:0] TYPE_WILL_NOTIFY = 8'h0C;
    localparam logic [7:0] TYPE_STILL_TRYING = 8'h0D;
    localparam logic [7:0] TYPE_READY = 8'h0E;
    // sub-types of the refusals
    localparam logic [3:0] SUB_NO_BUFFER = 4'h0;
    localparam logic [3:0] SUB_NO_TX_BLOCK = 4'h1;
    localparam logic [3:0] SUB_NO_CONNECTION = 4'h2;
    localparam logic [3:0] SUB_NO_REASSEMBLY = 4'h3;
    localparam logic [3:0] SUB_NO_MSG_NUMBER = 4'h4;
    localparam logic [3:0] SUB_NO_TRANS_BLOCK = 4'h5;
    // register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LOCAL_NODE = 8'h04;
    localparam logic [7:0] ADDR_MSG0 = 8'h08;
    localparam logic [7:0] ADDR_MSG1 = 8'h0C;
    localparam logic [7:0] ADDR_MSG2 = 8'h10;
    localparam logic [7:0] ADDR_CMD = 8'h14;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] MSG_RESET = 32'h0000_0000;
    localparam int CTRL_LOOP_BIT = 0;
    localparam int CTRL_PAD_LSB = 4;
    localparam int CTRL_HOST_LSB = 8;
    localparam int CMD_SEND_BIT = 0;

    function automatic logic usesHandling(input logic [7:0] t);
        return (t == 8'h00) || (t >= 8'h05 && t <= 8'h09) || (t >= 8'h0B && t <= 8'h0E);
    endfunction : usesHandling

    function automatic logic usesAddr(input logic [7:0] t);
        return usesHandling(t) || (t == 8'h04);
    endfunction : usesAddr

    function automatic logic usesMsgId(input logic [7:0] t);
        return usesHandling(t) || (t == 8'h02);
    endfunction : usesMsgId

    function automatic logic usesSub(input logic [7:0] t);
        return (t <= 8'h02) || (t >= 8'h04 && t <= 8'h07) || (t == 8'h09) || (t == 8'h0B) || (t == 8'h0C);
    endfunction : usesSub

    function automatic logic [95:0] buildLeader(input logic [7:0] t, input logic [7:0] hnd,
        input logic [7:0] host, input logic [15:0] node, input logic [11:0] id, input logic [3:0] sub,
        input logic [15:0] len);
        logic [95:0] v;
        v = '0;
        v[TYPE_LSB +: 8] = t;
        v[HANDLING_LSB +: 8] = usesHandling(t) ? hnd : 8'h00;
        v[HOST_LSB +: 8] = usesAddr(t) ? host : 8'h00;
        v[NODE_LSB +: 16] = usesAddr(t) ? node : 16'h0000;
        v[MSGID_LSB +: 12] = usesMsgId(t) ? id : 12'h000;
        v[SUB_LSB +: 4] = usesSub(t) ? sub : 4'h0;
        v[LEN_LSB +: 16] = (t == TYPE_REGULAR) ? len : 16'h0000;
        return v;
    endfunction : buildLeader
endpackage : node_leader_pkg

// ### test/host_receiver_model.sv
// Purpose: receiving host model for the framer serial output
// Assumes: host word of 16 bits; stalls one cycle in three
// Notes: keeps the last whole message in msg
`timescale 1ns/1ps
module host_receiver_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic hostBit,
    input wire logic hostValid,
    input wire logic hostLast,
    output logic hostReady
);
    logic [1:0] phase_r;
    logic [7:0] code;
    logic rx[$], msg[$];
    int msgCount, dropped;
    assign hostReady = !rst && phase_r != 2'h2;
    always @(posedge clk)
    begin
        if (rst)
        begin
            phase_r <= 2'h0;
            msgCount = 0;
            rx = {};
        end
        else
        begin
            phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
            if (hostValid && hostReady)
            begin
                rx.push_back(hostBit);
                if (hostLast)
                begin
                    while (rx.size() % 16 != 0)
                        rx.push_back(1'b0);
                    for (int i = 24; i < 32; i++)
                        code = {code[6:0], rx[i]};
                    if (rx.size() > 8160 || code >= 8'h0F)
                        dropped++;
                    else
                    begin
                        msg = rx;
                        msgCount++;
                    end
                    rx = {};
                end
            end
        end
    end
endmodule : host_receiver_model

// ### test/node_to_host_leader_and_padding_bench.sv
// Purpose: self-checking bench for the node-to-host leader framer
// Assumes: ack one cycle after request
// Notes: each scenario is one task
`timescale 1ns/1ps
module node_to_host_leader_and_padding_bench
    import node_leader_pkg::*;
();
    logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, refuseValid, refuseMarkable, refuseReady;
    logic resourceFree, netValid, netBit, netLast, netReady, loopValid, loopBit, loopLast, loopReady;
    logic hostBit, hostValid, hostLast, hostReady;
    logic [7:0] wb_adr_i, refuseHandling, refuseHost, netHandling, netHost, loopHandling;
    logic [3:0] wb_sel_i, refuseCode, netSub, loopSub;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [15:0] refuseNode, netNode, netLength, loopLength;
    logic [11:0] refuseMsgId, netMsgId, loopMsgId;
    int err_total, samples_checked, cycles, nMsg;
    node_leader_framer uut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .refuseValid, .refuseMarkable, .refuseCode, .refuseHandling, .refuseHost,
        .refuseNode, .refuseMsgId, .refuseReady, .resourceFree, .netValid, .netBit, .netLast, .netHandling,
        .netHost, .netNode, .netMsgId, .netSub, .netLength, .netReady, .loopValid, .loopBit, .loopLast,
        .loopHandling, .loopMsgId, .loopSub, .loopLength, .loopReady, .hostBit, .hostValid, .hostLast,
        .hostReady);
    host_receiver_model mdl (.clk, .rst, .hostBit, .hostValid, .hostLast, .hostReady);
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    function automatic logic [95:0] lead();
        logic [95:0] v;
        for (int i = 0; i < 96; i++)
            v[95 - i] = mdl.msg[i];
        return v;
    endfunction : lead
    function automatic logic [95:0] refLead(input logic [7:0] t, input logic [11:0] id, input logic [3:0] c,
        input logic [3:0] s);
        return {24'h0, t, id[7:0], ~id[7:0], id[7:0], 4'hC, c, id, s, 16'h0};
    endfunction : refLead
    task automatic waitMsg();
        int k = 0;
        nMsg++;
        while (mdl.msgCount < nMsg && k < 3000)
        begin
            @(posedge clk);
            k++;
        end
        chk(96'(mdl.msgCount), 96'(nMsg));
    endtask : waitMsg
    task automatic refuse(input logic mk, input logic [3:0] c, input logic [11:0] id);
        @(posedge clk);
        refuseValid <= 1'b1;
        refuseMarkable <= mk;
        refuseCode <= c;
        refuseMsgId <= id;
        refuseHandling <= id[7:0];
        refuseHost <= ~id[7:0];
        refuseNode <= {id[7:0], 4'hC, c};
        do @(posedge clk); while (refuseReady !== 1'b1);
        refuseValid <= 1'b0;
    endtask : refuse
    task automatic stream(input logic lp, input logic [15:0] data, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            netValid <= !lp;
            loopValid <= lp;
            netBit <= data[i];
            loopBit <= data[i];
            netLast <= (i == 0);
            loopLast <= (i == 0);
            do @(posedge clk); while ((lp ? loopReady : netReady) !== 1'b1);
        end
        netValid <= 1'b0;
        loopValid <= 1'b0;
    endtask : stream
    task automatic chkBody(input int pad, input logic [15:0] data, input int n);
        logic e[$];
        for (int i = 0; i < pad * 16; i++)
            e.push_back(1'b0);
        for (int i = n - 1; i >= 0; i--)
            e.push_back(data[i]);
        e.push_back(1'b1);
        while ((e.size() - pad * 16) % 16 != 0)
            e.push_back(1'b0);
        chk(96'(mdl.msg.size()), 96'(e.size() + 96));
        for (int i = 0; i < e.size(); i++)
            chk(96'(mdl.msg[96 + i]), 96'(e[i]));
    endtask : chkBody
    task automatic t_regs();
        wb(1'b0, ADDR_CTRL, 32'h0);
        chk(96'(rd), 96'(CTRL_RESET));
        wb(1'b1, ADDR_CTRL, 32'h0000_3C10);
        wb(1'b0, ADDR_CTRL, 32'h0);
        chk(96'(rd), 96'h3C10);
        wb(1'b1, 8'h40, 32'hFFFF_FFFF);
        wb(1'b0, 8'h40, 32'h0);
        chk(96'(rd), 96'h0);
        wb(1'b1, ADDR_MSG0, 32'h00AA_0302);
        wb(1'b1, ADDR_MSG1, 32'h0012_3456);
        wb(1'b1, ADDR_MSG2, 32'h0000_0BCD);
        wb(1'b1, ADDR_CMD, 32'h0000_0001);
        waitMsg();
        chk(lead(), {24'h0, 8'h02, 8'h00, 8'h00, 16'h0000, 12'hBCD, 4'h3, 16'h0});
        $display("test regs done");
    endtask : t_regs
    task automatic t_refusals();
        for (int c = 0; c < 2; c++)
        begin
            refuse(1'b0, 4'(c), 12'h0A0 + 12'(c));
            waitMsg();
            chk(lead(), refLead(TYPE_TRY_AGAIN, 12'h0A0 + 12'(c), 4'(c), 4'(c)));
        end
        for (int c = 2; c < 6; c++)
        begin
            refuse(1'b1, 4'(c), 12'h100 + 12'(c));
            waitMsg();
            chk(lead(), refLead(TYPE_WILL_NOTIFY, 12'h100 + 12'(c), 4'(c), 4'(c)));
            refuse(1'b1, 4'(c), 12'h200 + 12'(c));
            waitMsg();
            chk(lead(), refLead(TYPE_STILL_TRYING, 12'h200 + 12'(c), 4'(c), 4'h0));
            resourceFree <= 1'b1;
            @(posedge clk);
            resourceFree <= 1'b0;
            waitMsg();
            chk(lead(), refLead(TYPE_READY, 12'h100 + 12'(c), 4'(c), 4'h0));
        end
        $display("test refusals done");
    endtask : t_refusals
    task automatic t_regular();
        netHandling <= 8'h5A;
        netHost <= 8'h33;
        netNode <= 16'h4455;
        netMsgId <= 12'h777;
        netSub <= 4'h1;
        netLength <= 16'h1234;
        fork
            begin
                refuse(1'b0, 4'h1, 12'h3C3);
                waitMsg();
                chk(lead(), refLead(TYPE_TRY_AGAIN, 12'h3C3, 4'h1, 4'h1));
            end
            begin
                repeat (2) @(posedge clk);
                stream(1'b0, 16'h0016, 5);
            end
        join
        waitMsg();
        chk(lead(), {24'h0, 8'h00, 8'h5A, 8'h33, 16'h4455, 12'h777, 4'h1, 16'h1234});
        chkBody(1, 16'h0016, 5);
        $display("test regular done");
    endtask : t_regular
    task automatic t_loop();
        wb(1'b1, ADDR_LOCAL_NODE, 32'h0000_0077);
        wb(1'b1, ADDR_CTRL, 32'h0000_3C01);
        loopHandling <= 8'h66;
        loopMsgId <= 12'h9AB;
        loopSub <= 4'h2;
        loopLength <= 16'h0003;
        stream(1'b1, 16'h0007, 3);
        waitMsg();
        chk(lead(), {24'h0, 8'h00, 8'h66, 8'h3C, 16'h0077, 12'h9AB, 4'h2, 16'h0003});
        chkBody(0, 16'h0007, 3);
        $display("test loop done");
    endtask : t_loop
    initial
    begin
        {clk, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, refuseValid, refuseMarkable, refuseCode} = '0;
        {refuseHandling, refuseHost, refuseNode, refuseMsgId, resourceFree, netValid, netBit, netLast} = '0;
        {netHandling, netHost, netNode, netMsgId, netSub, netLength, loopValid, loopBit, loopLast} = '0;
        {loopHandling, loopMsgId, loopSub, loopLength} = '0;
        wb_sel_i = 4'hF;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_refusals();
        t_regular();
        t_loop();
        chk(96'(mdl.msgCount), 96'(nMsg));
        tally_and_finish();
    end
endmodule : node_to_host_leader_and_padding_bench
